// [design/xfp_pkg.sv]
// Functional notes
// - extended: B7h enters, E9h leaves 4-byte mode
// - octal always four address bytes
// - B9h enters, ABh leaves deep power-down
// - E8h variable address, 8 dummy octal
// - E5h variable address, one byte, stores lock
// - E2h four address bytes, 8 dummy octal
// - E3h four address bytes programs lock bit
// - E4h erases all nonvolatile lock bits
// - A7h reads freeze bit, A6h sets it
// - 27h password out low byte first, repeats
// - E0h/E1h always four address bytes
// - CDh no address, pattern after dummy
// - pattern dummy is octal setting plus two
// - discovery read: three bytes extended, four octal
// - variable address: four if mode or octal
// - 66h then 99h alone causes reset
// - host deselects, then keeps deselect gap
// - reset reloads volatile state from nonvolatile
// - reset aborts running write, program, erase
// - reset done when status bit 7 reads 1
// - 66h ignored during register writes
// - host leaves execute-in-place before reset pair
package xfp_pkg;
	localparam logic [7:0] OP_EN4 = 8'hB7;
	localparam logic [7:0] OP_EX4 = 8'hE9;
	localparam logic [7:0] OP_DPD = 8'hB9;
	localparam logic [7:0] OP_RDP = 8'hAB;
	localparam logic [7:0] OP_RVL = 8'hE8;
	localparam logic [7:0] OP_WVL = 8'hE5;
	localparam logic [7:0] OP_RNL = 8'hE2;
	localparam logic [7:0] OP_WNL = 8'hE3;
	localparam logic [7:0] OP_ENL = 8'hE4;
	localparam logic [7:0] OP_RFZ = 8'hA7;
	localparam logic [7:0] OP_WFZ = 8'hA6;
	localparam logic [7:0] OP_RPW = 8'h27;
	localparam logic [7:0] OP_WPW = 8'h28;
	localparam logic [7:0] OP_UPW = 8'h29;
	localparam logic [7:0] OP_RVL4 = 8'hE0;
	localparam logic [7:0] OP_WVL4 = 8'hE1;
	localparam logic [7:0] OP_DLP = 8'hCD;
	localparam logic [7:0] OP_SFDP = 8'h5A;
	localparam logic [7:0] OP_RFS = 8'h70;
	localparam logic [7:0] OP_RSTEN = 8'h66;
	localparam logic [7:0] OP_RSTM = 8'h99;
	localparam logic [5:0] OCT_DUMMY = 6'h08;
	localparam logic [5:0] SFDP_DUMMY = 6'h08;
	localparam logic [5:0] DLP_EXTRA = 6'h02;
	localparam logic [4:0] DUMMY_DEF = 5'h10;
	localparam logic [3:0] PW_BYTES = 4'h8;
	localparam logic [2:0] ADDR3 = 3'h3;
	localparam logic [2:0] ADDR4 = 3'h4;
	localparam logic [7:0] DLP_PATTERN = 8'h55;
	localparam logic [63:0] PW_DEF = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam int SEC_LO = 17;
	localparam int SEC_BITS = 6;
	localparam int FSR_READY_BIT = 7;
	localparam int RST_BUSY_CYC = 16;
	// host register map, byte addresses
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_TXLO = 8'h08;
	localparam logic [7:0] REG_TXHI = 8'h0C;
	localparam logic [7:0] REG_RXLEN = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam logic [7:0] REG_RXLO = 8'h18;
	localparam logic [7:0] REG_RXHI = 8'h1C;
	localparam real CLK_NS = 4.0;
	localparam real MIN_DESELECT_GAP_NS = 50.0;
	localparam int MIN_DESELECT_GAP_CYC = int'($ceil(MIN_DESELECT_GAP_NS / CLK_NS));

	typedef struct packed {
		logic ok; // code accepted in this protocol
		logic rd; // device returns data
		logic [2:0] na; // address bytes
		logic [5:0] nd; // dummy slots
		logic [3:0] nin; // data bytes from host
	} xfp_cmd_t;

	// shape of one command; shared so both ends count the same slots
	function automatic xfp_cmd_t xfp_cmd_info(input logic [7:0] op, input logic octal,
			input logic addr4, input logic [4:0] dummy);
		xfp_cmd_t c;
		logic [2:0] av;
		c = '0;
		av = (addr4 || octal) ? ADDR4 : ADDR3;
		c.ok = 1'b1;
		unique case (op)
			OP_EN4, OP_EX4: c.ok = !octal;
			OP_DPD, OP_RDP, OP_ENL, OP_WFZ, OP_RSTEN, OP_RSTM: c.ok = 1'b1;
			OP_RVL: begin c.na = av; c.rd = 1'b1; c.nd = octal ? OCT_DUMMY : '0; end
			OP_WVL: begin c.na = av; c.nin = 4'h1; end
			OP_RNL, OP_RVL4: begin c.na = ADDR4; c.rd = 1'b1; c.nd = octal ? OCT_DUMMY : '0; end
			OP_WNL: c.na = ADDR4;
			OP_WVL4: begin c.na = ADDR4; c.nin = 4'h1; end
			OP_RFZ, OP_RPW: begin c.rd = 1'b1; c.nd = octal ? OCT_DUMMY : '0; end
			OP_WPW, OP_UPW: c.nin = PW_BYTES;
			OP_DLP: begin c.rd = 1'b1; c.nd = {1'b0, dummy} + DLP_EXTRA; end
			OP_SFDP: begin c.na = octal ? ADDR4 : ADDR3; c.rd = 1'b1; c.nd = SFDP_DUMMY; end
			OP_RFS: c.rd = 1'b1;
			default: c.ok = 1'b0;
		endcase
		return c;
	endfunction : xfp_cmd_info
endpackage : xfp_pkg

// [design/xfp_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
// byte-slot model of the expanded serial bus: one tick carries one slot
interface xfp_link_if;
	logic sel_n; // chip select, host drives
	logic tick; // slot strobe, host drives
	logic [7:0] hq; // host to device byte
	logic [7:0] dq; // device to host byte
	logic dq_oe; // device drives dq
	logic octal; // device protocol is octal DDR
	logic addr4; // device in 4-byte address mode
	logic [4:0] dummy; // device octal dummy setting
	modport dev (input sel_n, tick, hq, output dq, dq_oe, octal, addr4, dummy);
	modport host (output sel_n, tick, hq, input dq, dq_oe, octal, addr4, dummy);
endinterface : xfp_link_if
`default_nettype wire

// [design/xfp_dev.sv]
`timescale 1ns/100ps
`default_nettype none
module xfp_dev (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset
	xfp_link_if.dev lnk, // serial link
	input wire logic nv_octal, // nonvolatile protocol select
	input wire logic nv_addr4, // nonvolatile 4-byte default
	input wire logic [4:0] nv_dummy, // nonvolatile dummy setting
	input wire logic wrsr_busy, // status register write running
	input wire logic wrnv_busy, // nonvolatile config write running
	input wire logic pe_busy, // write/program/erase active or suspended
	output logic abort_pe, // abort pulse to array engine
	output logic dpd, // in deep power-down
	output logic pw_ok // password unlocked
);
	import xfp_pkg::*;

	typedef enum logic [2:0] {
		XFP_IDLE = 3'b000, XFP_ADDR = 3'b001, XFP_DUM = 3'b011,
		XFP_DOUT = 3'b010, XFP_DIN = 3'b110, XFP_SKIP = 3'b111
	} xfp_dst_t;

	xfp_dst_t st_ff;
	xfp_cmd_t cmd_ff;
	logic [7:0] op_ff;
	logic [31:0] addr_ff;
	logic [5:0] cnt_ff;
	logic [63:0] din_ff;
	logic [3:0] nin_ff;
	logic [2:0] oidx_ff;
	logic sel_d_ff, addr4_ff, octal_ff, freeze_ff, dpd_ff, rsten_ff, ready_ff, pwok_ff, abort_ff;
	logic [4:0] dummy_ff;
	logic [7:0] dq_ff;
	logic dqoe_ff;
	logic [7:0] vlock_ff [2**SEC_BITS];
	logic [2**SEC_BITS-1:0] nvlock_ff;
	logic [63:0] pw_ff;
	logic [7:0] rstcnt_ff;
	xfp_cmd_t ci;
	logic tk, done, done_ok, srst;
	logic [SEC_BITS-1:0] sec;

	assign tk = lnk.tick && !lnk.sel_n;
	assign done = sel_d_ff && lnk.sel_n; // deselect ends the command
	assign ci = xfp_cmd_info(lnk.hq, octal_ff, addr4_ff, dummy_ff);
	assign sec = addr_ff[SEC_LO +: SEC_BITS];
	// command complete only when every expected slot arrived
	assign done_ok = done && cmd_ff.ok && (st_ff == XFP_IDLE ? 1'b0 :
		(st_ff == XFP_DOUT) || (st_ff == XFP_DIN && nin_ff == cmd_ff.nin) ||
		(st_ff == XFP_ADDR && cnt_ff == '0));
	assign srst = done_ok && op_ff == OP_RSTM && rsten_ff;

	// select edge tracker
	always_ff @(posedge clk_sys) begin
		if (rst) sel_d_ff <= 1'b0;
		else sel_d_ff <= !lnk.sel_n;
	end

	// slot sequencer
	always_ff @(posedge clk_sys) begin
		if (rst || lnk.sel_n) begin
			st_ff <= XFP_IDLE;
			cmd_ff <= '0;
			op_ff <= 8'h00;
			cnt_ff <= '0;
			nin_ff <= '0;
			oidx_ff <= '0;
		end else if (tk) begin
			unique case (st_ff)
				XFP_IDLE: begin
					op_ff <= lnk.hq;
					cmd_ff <= ci;
					cnt_ff <= {3'h0, ci.na};
					// power-down hears only the release code; unknown codes sink the frame
					if (!ci.ok || (dpd_ff && lnk.hq != OP_RDP)) st_ff <= XFP_SKIP;
					else if (ci.na != '0) st_ff <= XFP_ADDR;
					else if (ci.nd != '0) begin st_ff <= XFP_DUM; cnt_ff <= ci.nd; end
					else if (ci.rd) st_ff <= XFP_DOUT;
					else if (ci.nin != '0) st_ff <= XFP_DIN;
					else st_ff <= XFP_ADDR; // command-only, waits for deselect
				end
				XFP_ADDR: begin
					if (cnt_ff != '0) cnt_ff <= cnt_ff - 6'h01;
					if (cnt_ff == 6'h01) begin
						if (cmd_ff.nd != '0) begin st_ff <= XFP_DUM; cnt_ff <= cmd_ff.nd; end
						else if (cmd_ff.rd) st_ff <= XFP_DOUT;
						else if (cmd_ff.nin != '0) st_ff <= XFP_DIN;
					end
				end
				XFP_DUM: begin
					cnt_ff <= cnt_ff - 6'h01;
					if (cnt_ff == 6'h01) st_ff <= cmd_ff.rd ? XFP_DOUT : XFP_DIN;
				end
				XFP_DOUT: oidx_ff <= oidx_ff + 3'h1; // wraps, password repeats
				XFP_DIN: if (nin_ff != cmd_ff.nin) nin_ff <= nin_ff + 4'h1; // extra bytes dropped
				XFP_SKIP: st_ff <= XFP_SKIP;
				default: st_ff <= XFP_SKIP;
			endcase
		end
	end

	// address and write data capture, address MSB first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addr_ff <= '0;
			din_ff <= '0;
		end else if (tk && st_ff == XFP_ADDR && cnt_ff != '0) begin
			addr_ff <= {addr_ff[23:0], lnk.hq};
		end else if (tk && st_ff == XFP_DIN && nin_ff != cmd_ff.nin) begin
			din_ff[nin_ff[2:0]*8 +: 8] <= lnk.hq; // first byte lowest
		end else if (tk && st_ff == XFP_IDLE) begin
			addr_ff <= '0;
		end
	end

	// read data, registered on the slot tick, held until the next
	always_ff @(posedge clk_sys) begin
		if (rst || lnk.sel_n) begin
			dq_ff <= 8'h00;
			dqoe_ff <= 1'b0;
		end else if (tk && (st_ff == XFP_DOUT || (st_ff != XFP_IDLE && st_ff != XFP_SKIP &&
				cmd_ff.rd && ((st_ff == XFP_DUM && cnt_ff == 6'h01) ||
				(st_ff == XFP_ADDR && cnt_ff == 6'h01 && cmd_ff.nd == '0))))) begin
			dqoe_ff <= 1'b1;
			unique case (op_ff)
				OP_RVL, OP_RVL4: dq_ff <= vlock_ff[sec];
				OP_RNL: dq_ff <= {7'h00, nvlock_ff[sec]};
				OP_RFZ: dq_ff <= {7'h00, freeze_ff};
				OP_RPW: dq_ff <= pw_ff[((st_ff == XFP_DOUT) ? oidx_ff : 3'h0)*8 +: 8];
				OP_DLP: dq_ff <= DLP_PATTERN;
				OP_RFS: dq_ff <= {ready_ff && !pe_busy, 7'h00};
				default: dq_ff <= 8'h00;
			endcase
		end
	end
	// each data tick reloads its own byte; the early load only raises the enable before data

	// address mode and volatile configuration, reloaded by either reset
	always_ff @(posedge clk_sys) begin
		if (rst || srst) begin
			addr4_ff <= nv_addr4;
			octal_ff <= nv_octal;
			dummy_ff <= nv_dummy;
		end else if (done_ok && op_ff == OP_EN4) begin
			addr4_ff <= 1'b1;
		end else if (done_ok && op_ff == OP_EX4) begin
			addr4_ff <= 1'b0;
		end
	end

	// volatile locks, freeze and power-down
	always_ff @(posedge clk_sys) begin
		if (rst || srst) begin
			for (int i = 0; i < 2**SEC_BITS; i++) vlock_ff[i] <= 8'h00;
			freeze_ff <= 1'b0;
			dpd_ff <= 1'b0;
			pwok_ff <= 1'b0;
		end else if (done_ok) begin
			if (op_ff == OP_WVL || op_ff == OP_WVL4) vlock_ff[sec] <= din_ff[7:0];
			if (op_ff == OP_WFZ) freeze_ff <= 1'b1;
			if (op_ff == OP_DPD) dpd_ff <= 1'b1;
			if (op_ff == OP_RDP) dpd_ff <= 1'b0;
			if (op_ff == OP_UPW) pwok_ff <= din_ff == pw_ff;
		end
	end

	// nonvolatile state survives a soft reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nvlock_ff <= '0;
			pw_ff <= PW_DEF;
		end else if (done_ok) begin
			if (op_ff == OP_WNL) nvlock_ff[sec] <= 1'b1;
			if (op_ff == OP_ENL) nvlock_ff <= '0;
			if (op_ff == OP_WPW) pw_ff <= din_ff;
		end
	end

	// reset pairing: any other finished command breaks the pair
	always_ff @(posedge clk_sys) begin
		if (rst || srst) rsten_ff <= 1'b0;
		else if (done_ok) rsten_ff <= op_ff == OP_RSTEN && !wrsr_busy && !wrnv_busy;
		else if (done) rsten_ff <= 1'b0;
	end

	// reset recovery counter and abort of array work
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rstcnt_ff <= '0;
			ready_ff <= 1'b1;
			abort_ff <= 1'b0;
		end else begin
			abort_ff <= srst && pe_busy;
			if (srst) begin
				rstcnt_ff <= 8'(RST_BUSY_CYC);
				ready_ff <= 1'b0;
			end else if (rstcnt_ff != '0) begin
				rstcnt_ff <= rstcnt_ff - 8'h01;
				ready_ff <= rstcnt_ff == 8'h01;
			end
		end
	end

	assign lnk.dq = dq_ff;
	assign lnk.dq_oe = dqoe_ff;
	assign lnk.octal = octal_ff;
	assign lnk.addr4 = addr4_ff;
	assign lnk.dummy = dummy_ff;
	assign abort_pe = abort_ff;
	assign dpd = dpd_ff;
	assign pw_ok = pwok_ff;
endmodule : xfp_dev
`default_nettype wire

// [design/xfp_host.sv]
`timescale 1ns/100ps
`default_nettype none
module xfp_host (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset
	xfp_link_if.host lnk, // serial link
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata // read data, cycle after rd
);
	import xfp_pkg::*;

	typedef enum logic [1:0] {XFH_IDLE = 2'b00, XFH_SEL = 2'b01, XFH_GAP = 2'b11} xfh_st_t;

	xfh_st_t st_ff;
	xfp_cmd_t cmd_ff;
	logic [7:0] op_ff, hq_ff;
	logic [31:0] addr_ff, rdata_ff;
	logic [63:0] tx_ff, rx_ff;
	logic [3:0] rxlen_ff;
	logic [6:0] slot_ff, last_ff;
	logic [3:0] ridx_ff;
	logic ph_ff, cap_ff, busy;
	logic [7:0] gap_ff;
	logic [6:0] dbase;
	xfp_cmd_t nc;

	assign busy = st_ff != XFH_IDLE;
	// shape of the code being written, decoded once for both uses below
	assign nc = xfp_cmd_info(wdata[7:0], lnk.octal, lnk.addr4, lnk.dummy);
	assign dbase = 7'h01 + {4'h0, cmd_ff.na} + {1'h0, cmd_ff.nd};

	// frame sequencer; the gap after deselect spaces back-to-back frames
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_ff <= XFH_IDLE;
			op_ff <= 8'h00;
			cmd_ff <= '0;
			slot_ff <= '0;
			last_ff <= '0;
			ph_ff <= 1'b0;
			gap_ff <= '0;
		end else unique case (st_ff)
			XFH_IDLE: if (wr && addr == REG_CMD) begin
				op_ff <= wdata[7:0];
				cmd_ff <= nc;
				last_ff <= 7'h01 + {4'h0, nc.na} + {1'h0, nc.nd}
					+ (nc.rd ? {3'h0, rxlen_ff} : {3'h0, nc.nin});
				slot_ff <= '0;
				ph_ff <= 1'b0;
				st_ff <= XFH_SEL;
			end
			XFH_SEL: begin
				ph_ff <= !ph_ff; // divider: tick on every second cycle
				if (ph_ff) slot_ff <= slot_ff + 7'h01;
				if (ph_ff && slot_ff + 7'h01 == last_ff) begin
					st_ff <= XFH_GAP; // deselect starts the device action
					gap_ff <= 8'(MIN_DESELECT_GAP_CYC);
				end
			end
			XFH_GAP: begin
				gap_ff <= gap_ff - 8'h01;
				if (gap_ff == 8'h01) st_ff <= XFH_IDLE;
			end
			default: st_ff <= XFH_IDLE;
		endcase
	end

	// slot byte: opcode, address MSB first, dummy, then write data low byte first
	always_ff @(posedge clk_sys) begin
		if (rst) hq_ff <= 8'h00;
		else if (st_ff == XFH_SEL && !ph_ff) begin
			if (slot_ff == '0) hq_ff <= op_ff;
			else if (slot_ff <= {4'h0, cmd_ff.na}) hq_ff <= addr_ff[(3'(cmd_ff.na - slot_ff[2:0]))*8 +: 8];
			else if (slot_ff >= dbase && !cmd_ff.rd) hq_ff <= tx_ff[(3'(slot_ff - dbase))*8 +: 8];
			else hq_ff <= 8'h00;
		end
	end

	// capture of returned bytes one cycle after their tick
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cap_ff <= 1'b0;
			ridx_ff <= '0;
			rx_ff <= '0;
		end else begin
			cap_ff <= st_ff == XFH_SEL && ph_ff && cmd_ff.rd && slot_ff >= dbase;
			if (st_ff == XFH_IDLE && wr && addr == REG_CMD) ridx_ff <= '0;
			else if (cap_ff) begin
				if (ridx_ff < 4'h8) rx_ff[ridx_ff[2:0]*8 +: 8] <= lnk.dq; // later bytes dropped
				ridx_ff <= ridx_ff + 4'h1;
			end
		end
	end

	// software-written settings; ignored while a frame runs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addr_ff <= '0;
			tx_ff <= '0;
			rxlen_ff <= 4'h1;
		end else if (wr && !busy) begin
			if (addr == REG_ADDR) addr_ff <= wdata;
			if (addr == REG_TXLO) tx_ff[31:0] <= wdata;
			if (addr == REG_TXHI) tx_ff[63:32] <= wdata;
			if (addr == REG_RXLEN) rxlen_ff <= wdata[3:0];
		end
	end

	// read port; unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (rst) rdata_ff <= '0;
		else if (rd) unique case (addr)
			REG_CMD: rdata_ff <= {24'h0, op_ff};
			REG_ADDR: rdata_ff <= addr_ff;
			REG_TXLO: rdata_ff <= tx_ff[31:0];
			REG_TXHI: rdata_ff <= tx_ff[63:32];
			REG_RXLEN: rdata_ff <= {28'h0, rxlen_ff};
			REG_STAT: rdata_ff <= {28'h0, lnk.dummy == DUMMY_DEF, lnk.addr4, lnk.octal, busy};
			REG_RXLO: rdata_ff <= rx_ff[31:0];
			REG_RXHI: rdata_ff <= rx_ff[63:32];
			default: rdata_ff <= '0;
		endcase
		else rdata_ff <= '0;
	end

	assign lnk.sel_n = st_ff != XFH_SEL;
	assign lnk.tick = st_ff == XFH_SEL && ph_ff;
	assign lnk.hq = hq_ff;
	assign rdata = rdata_ff;
endmodule : xfp_host
`default_nettype wire

// [test/xfp_link_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// watches the link between the two ends
module xfp_link_sva
	import xfp_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic rst, // sync reset
	input wire logic sel_n, // chip select
	input wire logic tick, // slot strobe
	input wire logic [7:0] hq, // host byte
	input wire logic [7:0] dq, // device byte
	input wire logic dq_oe, // device drives dq
	input wire logic octal, // octal protocol
	input wire logic addr4, // 4-byte mode
	input wire logic [4:0] dummy // dummy setting
);
	logic [5:0] cnt_ff; // slots seen in this frame
	logic [7:0] op_ff; // opcode of this frame
	logic [5:0] gap_ff; // cycles deselected, saturating

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// count cleared between frames so each frame is judged alone
	always_ff @(posedge clk_sys) begin
		if (rst || sel_n)
			cnt_ff <= 6'h00;
		else if (tick)
			cnt_ff <= cnt_ff + 6'h01;
	end

	// first slot of a frame carries the opcode
	always_ff @(posedge clk_sys) begin
		if (tick && !sel_n && cnt_ff == 6'h00)
			op_ff <= hq;
	end

	// starts full: a frame may follow reset release at once
	always_ff @(posedge clk_sys) begin
		if (rst)
			gap_ff <= 6'h3F;
		else if (!sel_n)
			gap_ff <= 6'h00;
		else if (gap_ff != 6'h3F)
			gap_ff <= gap_ff + 6'h01;
	end

	deselect_gap_a: assert property ($fell(sel_n) |-> gap_ff >= MIN_DESELECT_GAP_CYC)
		else $error("deselect gap too short");
	octal_addr_a: assert property (octal && $past(octal) |-> $stable(addr4))
		else $error("address mode moved in octal");
	mode_frame_a: assert property ($changed(addr4) |-> sel_n)
		else $error("address mode moved inside frame");
	oe_idle_a: assert property (sel_n && $past(sel_n) |-> !dq_oe)
		else $error("device drives while deselected");
	vlock_len_a: assert property ($rose(sel_n) && cnt_ff != 6'h00 && op_ff == OP_WVL
		|-> cnt_ff == ((addr4 || octal) ? 6'h06 : 6'h05)) else $error("lock write slot count");
	nvlock_len_a: assert property ($rose(sel_n) && cnt_ff != 6'h00 && op_ff == OP_WNL |-> cnt_ff == 6'h05)
		else $error("nonvolatile lock slot count");
	pw_len_a: assert property ($rose(sel_n) && cnt_ff != 6'h00 && (op_ff == OP_WPW || op_ff == OP_UPW)
		|-> cnt_ff == 6'h09) else $error("password slot count");
	rst_len_a: assert property ($rose(sel_n) && cnt_ff != 6'h00 && (op_ff == OP_RSTEN || op_ff == OP_RSTM)
		|-> cnt_ff == 6'h01) else $error("reset code slot count");
	vread_lat_a: assert property ($rose(dq_oe) && op_ff == OP_RVL
		|-> cnt_ff == ((addr4 || octal) ? 6'h05 : 6'h04) + (octal ? 6'h08 : 6'h00)) else $error("lock read latency");
	dlp_lat_a: assert property ($rose(dq_oe) && op_ff == OP_DLP |-> cnt_ff == {1'b0, dummy} + 6'h03)
		else $error("pattern read latency");
	sfdp_lat_a: assert property ($rose(dq_oe) && op_ff == OP_SFDP |-> cnt_ff == (octal ? 6'h0D : 6'h0C))
		else $error("discovery read latency");
endmodule : xfp_link_sva
`default_nettype wire

// [test/xspi_flash_protect_reset_cmds_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module xspi_flash_protect_reset_cmds_bench;
	import xfp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic nv_octal = 1'b0;
	logic nv_addr4 = 1'b0;
	logic [4:0] nv_dummy = 5'h10;
	logic wrsr_busy = 1'b0;
	logic wrnv_busy = 1'b0;
	logic pe_busy = 1'b0;
	logic [31:0] rdata;
	logic abort_pe;
	logic dpd;
	logic pw_ok;
	int checks = 0;
	int bad_count = 0;
	int cyc = 0;
	int aborts = 0;
	int seed = 6662;
	logic [63:0] rx;
	logic [63:0] pw;
	logic [63:0] base;
	logic [31:0] st;
	logic [31:0] sa;
	logic [7:0] d;

	xfp_link_if xfp_link_if_inst();
	xfp_dev xfp_dev_inst(.clk_sys(clk_sys), .rst(rst), .lnk(xfp_link_if_inst), .nv_octal(nv_octal),
		.nv_addr4(nv_addr4), .nv_dummy(nv_dummy), .wrsr_busy(wrsr_busy), .wrnv_busy(wrnv_busy),
		.pe_busy(pe_busy), .abort_pe(abort_pe), .dpd(dpd), .pw_ok(pw_ok));
	xfp_host xfp_host_inst(.clk_sys(clk_sys), .rst(rst), .lnk(xfp_link_if_inst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	xfp_link_sva xfp_link_sva_inst(.clk_sys(clk_sys), .rst(rst), .sel_n(xfp_link_if_inst.sel_n),
		.tick(xfp_link_if_inst.tick), .hq(xfp_link_if_inst.hq), .dq(xfp_link_if_inst.dq),
		.dq_oe(xfp_link_if_inst.dq_oe), .octal(xfp_link_if_inst.octal), .addr4(xfp_link_if_inst.addr4),
		.dummy(xfp_link_if_inst.dummy));

	// 250 MHz
	always #2 clk_sys = ~clk_sys;

	// abort pulses counted; a hang is cut off well past the expected run
	always @(posedge clk_sys) begin
		if (abort_pe === 1'b1)
			aborts++;
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
		// hand back on a rising edge so later stimulus lands there
		@(posedge clk_sys);
	endtask : rd_reg

	// one whole frame; waits out busy and the deselect gap before the next
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [63:0] tx, input logic [3:0] n);
		int i;
		wr_reg(REG_ADDR, a);
		wr_reg(REG_TXLO, tx[31:0]);
		wr_reg(REG_TXHI, tx[63:32]);
		wr_reg(REG_RXLEN, {28'h0000000, n});
		wr_reg(REG_CMD, {24'h000000, op});
		for (i = 0; i < 200; i++) begin
			rd_reg(REG_STAT, st);
			if (st[0] === 1'b0)
				break;
		end
		if (i == 200) begin
			bad_count++;
			end_sim();
		end
		repeat (MIN_DESELECT_GAP_CYC) @(posedge clk_sys);
		rd_reg(REG_RXLO, rx[31:0]);
		rd_reg(REG_RXHI, rx[63:32]);
	endtask : frame

	function automatic logic [63:0] stat_of(input logic oc, input logic a4, input logic [4:0] dm);
		return {60'h0, dm == 5'h10, a4, oc, 1'b0};
	endfunction : stat_of

	// sector number sits in address bits 22:17
	function automatic logic [31:0] sec_addr(input logic [5:0] s);
		return {9'h000, s, 17'h00000};
	endfunction : sec_addr

	// random lock byte written and read back through a code pair
	task automatic lock_rt(input logic [7:0] wop, input logic [7:0] rop);
		sa = sec_addr(6'($random(seed)));
		d = 8'($random(seed));
		frame(wop, sa, 64'(d), 4'h0);
		frame(rop, sa, 64'h0, 4'h1);
		check(64'(rx[7:0]), 64'(d));
	endtask : lock_rt

	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rd_reg(REG_STAT, st);
		check(64'(st), stat_of(1'b0, 1'b0, 5'h10));
		for (int m = 0; m < 2; m++) begin
			frame(m ? OP_EX4 : OP_EN4, 32'h0, 64'h0, 4'h0);
			rd_reg(REG_STAT, st);
			check(64'(st), stat_of(1'b0, m == 0, 5'h10));
			repeat (3) lock_rt(OP_WVL, OP_RVL);
			lock_rt(OP_WVL4, OP_RVL4);
		end
		pw = {$random(seed), $random(seed)};
		frame(OP_WPW, 32'h0, pw, 4'h0);
		frame(OP_RPW, 32'h0, 64'h0, 4'h8);
		check(rx, pw);
		frame(OP_UPW, 32'h0, ~pw, 4'h0);
		check(64'(pw_ok), 64'h0);
		frame(OP_UPW, 32'h0, pw, 4'h0);
		check(64'(pw_ok), 64'h1);
		// a write sent while powered down must be dropped
		frame(OP_DPD, 32'h0, 64'h0, 4'h0);
		check(64'(dpd), 64'h1);
		frame(OP_WVL, sa, 64'(~d), 4'h0);
		frame(OP_RDP, 32'h0, 64'h0, 4'h0);
		check(64'(dpd), 64'h0);
		frame(OP_RVL4, sa, 64'h0, 4'h1);
		check(64'(rx[7:0]), 64'(d));
		frame(OP_RNL, sa, 64'h0, 4'h1);
		base = rx;
		frame(OP_WNL, sa, 64'h0, 4'h0);
		frame(OP_RNL, sa, 64'h0, 4'h1);
		check(64'(rx[7:0] !== base[7:0]), 64'h1);
		frame(OP_ENL, 32'h0, 64'h0, 4'h0);
		frame(OP_RNL, sa, 64'h0, 4'h1);
		check(64'(rx[7:0]), 64'(base[7:0]));
		frame(OP_RFZ, 32'h0, 64'h0, 4'h1);
		base = rx;
		frame(OP_WFZ, 32'h0, 64'h0, 4'h0);
		frame(OP_RFZ, 32'h0, 64'h0, 4'h1);
		check(64'(rx[7:0] !== base[7:0]), 64'h1);
		// reset pair falls through while a register write runs
		frame(OP_EN4, 32'h0, 64'h0, 4'h0);
		frame(OP_SFDP, 32'h0, 64'h0, 4'h1);
		pe_busy <= 1'b1;
		for (int k = 1; k < 3; k++) begin
			{wrnv_busy, wrsr_busy} <= 2'(k);
			frame(OP_RSTEN, 32'h0, 64'h0, 4'h0);
			frame(OP_RSTM, 32'h0, 64'h0, 4'h0);
		end
		{wrnv_busy, wrsr_busy} <= 2'b00;
		// another frame between the pair cancels the enable
		frame(OP_RSTEN, 32'h0, 64'h0, 4'h0);
		frame(OP_RFZ, 32'h0, 64'h0, 4'h1);
		frame(OP_RSTM, 32'h0, 64'h0, 4'h0);
		rd_reg(REG_STAT, st);
		check(64'(st), stat_of(1'b0, 1'b1, 5'h10));
		check(64'(aborts), 64'h0);
		frame(OP_RSTEN, 32'h0, 64'h0, 4'h0);
		frame(OP_RSTM, 32'h0, 64'h0, 4'h0);
		check(64'(aborts), 64'h1);
		rd_reg(REG_STAT, st);
		check(64'(st), stat_of(1'b0, 1'b0, 5'h10));
		check(64'(pw_ok), 64'h0);
		frame(OP_RVL4, sa, 64'h0, 4'h1);
		check(64'(rx[7:0]), 64'h0);
		frame(OP_RFZ, 32'h0, 64'h0, 4'h1);
		check(64'(rx[7:0]), 64'(base[7:0]));
		frame(OP_RFS, 32'h0, 64'h0, 4'h1);
		check(64'(rx[FSR_READY_BIT]), 64'h0);
		pe_busy <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			frame(OP_RFS, 32'h0, 64'h0, 4'h1);
			if (rx[FSR_READY_BIT] === 1'b1)
				break;
		end
		check(64'(rx[FSR_READY_BIT]), 64'h1);
		// second reset brings the device up in octal with a short dummy
		nv_octal <= 1'b1;
		nv_dummy <= 5'h0A;
		rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		frame(OP_EN4, 32'h0, 64'h0, 4'h0);
		rd_reg(REG_STAT, st);
		check(64'(st), stat_of(1'b1, 1'b0, 5'h0A));
		repeat (2) lock_rt(OP_WVL, OP_RVL);
		frame(OP_SFDP, 32'h0, 64'h0, 4'h1);
		frame(OP_DLP, 32'h0, 64'h0, 4'h2);
		check(64'(rx[15:0]), 64'({2{DLP_PATTERN}}));
		end_sim();
	end
endmodule : xspi_flash_protect_reset_cmds_bench
`default_nettype wire
